// ---- src/adc_result_pkg.sv ----
// constants, register map and carrier types of the converter result block
// How it works
// - result field holds 10-bit fraction vin/vref, all ones at or above reference.
// - in scan mode, lost-result flag sets when an unread result is overwritten.
// - completion flag sets on conversion end, clears on result register read.
// - status bits 7:0 mirror the eight channel completion flags.
// - status bits 15:8 mirror the eight channel lost-result flags.
// - combined flag is OR of completion flags ANDed with channel masks.
// - unused status bits read zero; unused result bits reset to zero.
// - scan off and trigger code 010-111 start conversion on selected edge.
// - interrupt request stands while the combined flag is one.
// - per-channel mask bits choose which completion flags reach the interrupt.
package adc_result_pkg;

  localparam int          NUM_CH        = 8;
  localparam int          RES_W         = 10;
  localparam int          ADDR_W        = 32;

  // register byte addresses
  localparam logic [31:0] CH0_RESULT_ADDR = 32'h4001c010;
  localparam logic [31:0] CH7_RESULT_ADDR = 32'h4001c02c;
  localparam logic [31:0] FLAGS_ADDR      = 32'h4001c030;
  localparam logic [31:0] CTRL_ADDR       = 32'h4001c040; // trigger control
  localparam logic [31:0] IRQ_STAT_ADDR   = 32'h4001c044; // sticky event status
  localparam logic [31:0] IRQ_MASK_ADDR   = 32'h4001c048; // event mask
  localparam logic [31:0] CH_MASK_ADDR    = 32'h4001c04c; // channel interrupt mask

  // field positions
  localparam int          RES_LSB       = 6;
  localparam int          LOST_BIT      = 30;
  localparam int          DONE_BIT      = 31;
  localparam int          FLG_DONE_LSB  = 0;
  localparam int          FLG_LOST_LSB  = 8;
  localparam int          FLG_IRQ_BIT   = 16;
  localparam int          CTL_TRIG_LSB  = 0;
  localparam int          CTL_EDGE_BIT  = 3;
  localparam int          CTL_SCAN_BIT  = 4;
  localparam int          TRIG_SRC_N    = 6;

  // reset values
  localparam logic [31:0] CTRL_RST      = 32'h00000000;
  localparam logic [7:0]  CH_MASK_RST   = 8'h00;
  localparam logic [2:0]  EVT_MASK_RST  = 3'h0;

  // trigger-select codes
  localparam logic [2:0]  TRIG_SRC_MIN  = 3'h2;
  localparam logic [2:0]  TRIG_SRC_MAX  = 3'h7;

  // event bits of the sticky status register
  localparam int          EVT_DONE      = 0;
  localparam int          EVT_LOST      = 1;
  localparam int          EVT_TRIG      = 2;
  localparam int          EVT_N         = 3;

  // one conversion result from the analog core
  typedef struct packed {
    logic             valid;
    logic [2:0]       chan;
    logic [RES_W-1:0] value;
  } conv_result_t;

  // register bus request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
  } bus_req_t;

endpackage : adc_result_pkg

// ---- src/adc_result_status_irq.sv ----
// result registers, status, interrupt and hardware trigger of the converter
//
// Strobed register access was chosen for this implementation.
module adc_result_status_irq
  import adc_result_pkg::*;
(
  input  wire logic              clk_i,       // 125 MHz clock
  input  wire logic              rst_i,       // async reset, active high
  input  wire bus_req_t          bus_i,       // register bus request
  output logic [31:0]            rdata_o,     // read data, cycle after read
  input  wire conv_result_t      result_i,    // conversion finished pulse + data
  input  wire logic [TRIG_SRC_N-1:0] trig_src_i, // trigger pins / timer matches
  output logic                   conv_start_o, // one-cycle start request
  output logic                   adc_irq_o,   // request to interrupt controller
  output logic                   evt_irq_o    // masked sticky event interrupt
);

  logic [RES_W-1:0]      res_reg [NUM_CH];
  logic [NUM_CH-1:0]     done_reg;
  logic [NUM_CH-1:0]     lost_reg;
  logic [NUM_CH-1:0]     ch_mask_reg;
  logic [31:0]           ctrl_reg;
  logic [EVT_N-1:0]      evt_stat_reg;
  logic [EVT_N-1:0]      evt_mask_reg;
  logic [TRIG_SRC_N-1:0] trig_prev_reg;
  logic                  combined_irq_flag;
  logic [NUM_CH-1:0]     rd_clear;
  logic [NUM_CH-1:0]     conv_hit;
  logic                  trig_event;
  logic [31:0]           flags_word;

  // true when an address is the result register address of channel n
  function automatic logic ch_hit(input logic [ADDR_W-1:0] a, input int n);
    ch_hit = (a == CH0_RESULT_ADDR + 32'(4 * n));
  endfunction : ch_hit

  // per-channel read-clear and completion strobes
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      assign rd_clear[g] = bus_i.rd && ch_hit(bus_i.addr, g);
      assign conv_hit[g] = result_i.valid && (result_i.chan == 3'(g));

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          res_reg[g] <= '0;
        else if (conv_hit[g])
          res_reg[g] <= result_i.value;
      end

      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          done_reg[g] <= 1'b0;
        else if (conv_hit[g])
          done_reg[g] <= 1'b1;
        else if (rd_clear[g])
          done_reg[g] <= 1'b0;
      end

      // overwrite of unread result in scan
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          lost_reg[g] <= 1'b0;
        else if (conv_hit[g] && done_reg[g] && !rd_clear[g] && ctrl_reg[CTL_SCAN_BIT])
          lost_reg[g] <= 1'b1;
        else if (rd_clear[g])
          lost_reg[g] <= 1'b0;
      end
    end
  endgenerate

  assign combined_irq_flag = |(done_reg & ch_mask_reg);

  assign adc_irq_o = combined_irq_flag;

  always_comb
  begin
    flags_word                                   = '0;
    flags_word[FLG_DONE_LSB +: NUM_CH]           = done_reg;
    flags_word[FLG_LOST_LSB +: NUM_CH]           = lost_reg;
    flags_word[FLG_IRQ_BIT]                      = combined_irq_flag;
  end

  // software-written control and masks
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_reg     <= CTRL_RST;
      ch_mask_reg  <= CH_MASK_RST;
      evt_mask_reg <= EVT_MASK_RST;
    end
    else if (bus_i.wr)
    begin
      if (bus_i.addr == CTRL_ADDR)
        ctrl_reg <= {27'h0, bus_i.wdata[4:0]};
      if (bus_i.addr == CH_MASK_ADDR)
        ch_mask_reg <= bus_i.wdata[NUM_CH-1:0];
      if (bus_i.addr == IRQ_MASK_ADDR)
        evt_mask_reg <= bus_i.wdata[EVT_N-1:0];
    end
  end

  // trigger source history for edge detect
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      trig_prev_reg <= '0;
    else
      trig_prev_reg <= trig_src_i;
  end

  always_comb
  begin
    logic [2:0] sel;
    logic       cur;
    logic       prv;
    logic [2:0] idx;
    sel        = ctrl_reg[CTL_TRIG_LSB +: 3];
    // codes below the trigger range would index past the source vector
    idx        = (sel >= TRIG_SRC_MIN) ? 3'(sel - TRIG_SRC_MIN) : 3'h0;
    cur        = trig_src_i[idx];
    prv        = trig_prev_reg[idx];
    trig_event = !ctrl_reg[CTL_SCAN_BIT] && (sel >= TRIG_SRC_MIN) && (sel <= TRIG_SRC_MAX)
                 && (ctrl_reg[CTL_EDGE_BIT] ? (prv && !cur) : (!prv && cur));
  end

  // start pulse from flop
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      conv_start_o <= 1'b0;
    else
      conv_start_o <= trig_event;
  end

  // sticky events, set wins over clear-on-read
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      evt_stat_reg <= '0;
    else
    begin
      if (bus_i.rd && bus_i.addr == IRQ_STAT_ADDR)
        evt_stat_reg <= '0;
      if (|conv_hit)
        evt_stat_reg[EVT_DONE] <= 1'b1;
      if (|(conv_hit & done_reg & ~rd_clear) && ctrl_reg[CTL_SCAN_BIT])
        evt_stat_reg[EVT_LOST] <= 1'b1;
      if (trig_event)
        evt_stat_reg[EVT_TRIG] <= 1'b1;
    end
  end

  assign evt_irq_o = |(evt_stat_reg & evt_mask_reg);

  // registered read data, zero for unmapped addresses
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (bus_i.rd)
    begin
      rdata_o <= '0;
      for (int n = 0; n < NUM_CH; n++)
        if (ch_hit(bus_i.addr, n))
          rdata_o <= {done_reg[n], lost_reg[n], 14'h0, res_reg[n], 6'h0};
      if (bus_i.addr == FLAGS_ADDR)
        rdata_o <= flags_word;
      if (bus_i.addr == CTRL_ADDR)
        rdata_o <= ctrl_reg;
      if (bus_i.addr == CH_MASK_ADDR)
        rdata_o <= {24'h0, ch_mask_reg};
      if (bus_i.addr == IRQ_STAT_ADDR)
        rdata_o <= {29'h0, evt_stat_reg};
      if (bus_i.addr == IRQ_MASK_ADDR)
        rdata_o <= {29'h0, evt_mask_reg};
    end
    else
      rdata_o <= '0;
  end

endmodule : adc_result_status_irq

// ---- sim/adc_checker_assertions.sv ----
// port assertions of the converter result block
module adc_checker_assertions
  import adc_result_pkg::*;
(
  input wire logic                  clk_i,        // clock
  input wire logic                  rst_i,        // reset
  input wire bus_req_t              bus_i,        // bus
  input wire logic [31:0]           rdata_o,      // rdata
  input wire conv_result_t          result_i,     // result
  input wire logic [TRIG_SRC_N-1:0] trig_src_i,   // triggers
  input wire logic                  conv_start_o, // start
  input wire logic                  adc_irq_o,    // irq
  input wire logic                  evt_irq_o     // event irq
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // reads of a result word and of the flags word
  sequence s_res_rd;
    bus_i.rd && bus_i.addr >= CH0_RESULT_ADDR && bus_i.addr <= CH7_RESULT_ADDR;
  endsequence
  sequence s_flg_rd;
    bus_i.rd && bus_i.addr == FLAGS_ADDR;
  endsequence
  AST_RESULT: assert property (result_i.valid ##2 bus_i.rd && bus_i.addr == CH0_RESULT_ADDR
    + {$past(result_i.chan, 2), 2'h0}
    |=> rdata_o[31] && rdata_o[15:6] == $past(result_i.value, 3))
    else $error("result word wrong");
  AST_RES_ZERO: assert property (s_res_rd |=> rdata_o[29:16] == 14'h0 && rdata_o[5:0] == 6'h0)
    else $error("result spare bits set");
  AST_FLG_ZERO: assert property (s_flg_rd |=> rdata_o[31:17] == 15'h0)
    else $error("flags spare bits set");
  AST_IRQ: assert property (s_flg_rd |=> rdata_o[16] == $past(adc_irq_o))
    else $error("irq differs from flag");
  AST_LOST: assert property (s_flg_rd |=> (rdata_o[15:8] & ~rdata_o[7:0]) == 8'h0)
    else $error("lost without done");
  AST_CLEAR: assert property (s_res_rd ##0 !result_i.valid ##1 s_flg_rd
    |=> !rdata_o[$past(bus_i.addr[4:2], 2) + 3'h4])
    else $error("done not cleared");
  AST_SETWIN: assert property (s_res_rd ##0 result_i.valid && bus_i.addr == CH0_RESULT_ADDR
    + {result_i.chan, 2'h0} ##2 bus_i.rd && bus_i.addr == $past(bus_i.addr, 2) |=> rdata_o[31])
    else $error("set lost to read");
  AST_TRIG: assert property (conv_start_o |-> $past(trig_src_i) != $past(trig_src_i, 2))
    else $error("start without edge");
endmodule : adc_checker_assertions

bind adc_result_status_irq adc_checker_assertions i_chk (.clk_i, .rst_i, .bus_i, .rdata_o,
  .result_i, .trig_src_i, .conv_start_o, .adc_irq_o, .evt_irq_o);

// ---- sim/irq_ctrl_model.sv ----
// interrupt controller stand-in counting taken requests
module irq_ctrl_model (
  input  wire logic clk_i,  // clock
  input  wire logic rst_i,  // reset
  input  wire logic irq_i,  // level request
  output int        taken_o // rising requests
);
  logic irq_reg; // last level
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_reg <= 1'b0;
      taken_o <= 0;
    end
    else
    begin
      irq_reg <= irq_i;
      taken_o <= taken_o + int'(irq_i && !irq_reg);
    end
  end
endmodule : irq_ctrl_model

// ---- sim/tb_top.sv ----
// self-checking bench of the converter result block
module tb_top
  import adc_result_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  bus_req_t bus_i = '0;
  conv_result_t result_i = '0;
  logic [5:0] trig_src_i = '0;
  logic [31:0] rdata_o, rd_seen, n;
  logic conv_start_o, adc_irq_o, evt_irq_o;
  int failures = 0, num_checks = 0, pulses = 0, taken;
  initial forever #4 clk_i = ~clk_i;
  adc_result_status_irq i_dut (.clk_i, .rst_i, .bus_i, .rdata_o, .result_i, .trig_src_i,
    .conv_start_o, .adc_irq_o, .evt_irq_o);
  irq_ctrl_model i_irq (.clk_i, .rst_i, .irq_i(adc_irq_o), .taken_o(taken));
  // count start pulses
  always @(posedge clk_i) if (conv_start_o === 1'b1) pulses++;
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one bus/result cycle, then an idle cycle
  task automatic cyc(input bus_req_t b, input conv_result_t r);
    bus_i <= b;
    result_i <= r;
    @(posedge clk_i);
    bus_i <= '0;
    result_i <= '0;
    #1 rd_seen = rdata_o;
    @(posedge clk_i);
  endtask : cyc
  task automatic wr(input logic [31:0] a, d);
    cyc('{1'b1, 1'b0, a, d}, '0);
  endtask : wr
  task automatic rd(input logic [31:0] a, exp);
    cyc('{1'b0, 1'b1, a, 32'h0}, '0);
    chk(rd_seen, exp);
  endtask : rd
  task automatic res(input logic [2:0] c, input logic [9:0] v);
    cyc('0, '{1'b1, c, v});
  endtask : res
  task automatic t_flags();
    rd(FLAGS_ADDR, 32'h0);
    rd(32'h4001c050, 32'h0);
    wr(CTRL_ADDR, 32'h10);
    wr(CH_MASK_ADDR, 32'h08);
    wr(IRQ_MASK_ADDR, 32'h3);
    res(3'h3, 10'h155);
    res(3'h3, 10'h3ff);
    chk(adc_irq_o, 1'b1);
    chk(evt_irq_o, 1'b1);
    rd(FLAGS_ADDR, 32'h00010808);
    rd(IRQ_STAT_ADDR, 32'h3);
    chk(evt_irq_o, 1'b0);
    rd(CH0_RESULT_ADDR + 32'h8, 32'h0);
    rd(CH0_RESULT_ADDR + 32'hc, 32'hc000ffc0);
    rd(FLAGS_ADDR, 32'h0);
    chk(32'(taken), 32'h1);
    res(3'h1, 10'h001);
    rd(CH0_RESULT_ADDR + 32'h4, 32'h80000040);
    chk(adc_irq_o, 1'b0);
    chk(evt_irq_o, 1'b1);
    wr(IRQ_MASK_ADDR, 32'h0);
    chk(evt_irq_o, 1'b0);
    cyc('{1'b0, 1'b1, CH0_RESULT_ADDR + 32'h4, 32'h0}, '{1'b1, 3'h1, 10'h002});
    rd(CH0_RESULT_ADDR + 32'h4, 32'h80000080);
  endtask : t_flags
  // start pulses for one control word and one source pattern
  task automatic pulse(input logic [31:0] ctl, input logic [5:0] src);
    int p0;
    wr(CTRL_ADDR, 32'h0);
    wr(CTRL_ADDR, ctl);
    p0 = pulses;
    trig_src_i <= src;
    repeat (3) @(posedge clk_i);
    trig_src_i <= 6'h0;
    repeat (3) @(posedge clk_i);
    n = 32'(pulses - p0);
  endtask : pulse
  task automatic t_trigger();
    for (int c = 0; c < 8; c++)
    begin
      pulse(32'(c), c > 1 ? 6'(1 << (c - 2)) : 6'h3f);
      chk(n, c > 1 ? 32'h1 : 32'h0);
    end
    pulse(32'h12, 6'h01);
    chk(n, 32'h0);
    pulse(32'h0a, 6'h01);
    chk(n, 32'h1);
  endtask : t_trigger
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_flags();
    t_trigger();
    test_done();
  end
  // bound on the whole run
  initial
  begin
    repeat (5000) @(posedge clk_i);
    failures++;
    test_done();
  end
endmodule : tb_top
